//--- logic/pma_pkg.sv
// Constants and types for the ternary service port
package pma_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SYMBOL_NS = 40;
  localparam int SYMBOL_CYCLES = (SYMBOL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_SILENCE_NS = 1200000;
  localparam int IDLE_SILENCE_SYMBOLS = IDLE_SILENCE_NS / SYMBOL_NS;
  localparam int STEP_W = 8;

  // ----------------------------------------
  // Ternary symbols, two-bit signed
  // ----------------------------------------
  typedef logic [1:0] tern_t;
  localparam tern_t TERN_ZERO = 2'h0;
  localparam tern_t TERN_POS = 2'h1;
  localparam tern_t TERN_NEG = 2'h3;
  localparam int PAIRS = 3;
  localparam int TERN_W = 2;

  // Type code, value arbitrary
  localparam logic [1:0] PMA_TYPE_T4 = 2'h1;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {LINK_FAIL = 2'b00, LINK_READY = 2'b01, LINK_OK = 2'b10} link_status_t;
  typedef enum logic [1:0] {CTL_ENABLE = 2'b00, CTL_SCAN = 2'b01, CTL_DISABLE = 2'b10} link_control_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_PREAMBLE = 2'b01, RX_DATA = 2'b10} rx_state_t;
  typedef enum logic [1:0] {TI_SILENT = 2'b00, TI_NEG = 2'b01, TI_POS = 2'b10} idle_phase_t;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_TYPE = 8'h10;

  typedef enum logic [2:0] {
    SEL_CTRL = 3'b000, SEL_STATUS = 3'b001, SEL_INT_STATUS = 3'b010,
    SEL_INT_MASK = 3'b011, SEL_TYPE = 3'b100, SEL_NONE = 3'b111
  } reg_sel_t;

  // Field positions
  localparam int CTRL_LINK_LSB = 0;
  localparam int STAT_LINK_LSB = 0;
  localparam int STAT_CARRIER = 2;
  localparam int STAT_RX_LSB = 3;
  localparam int STAT_STEP_LSB = 8;

  // Interrupt bits
  localparam int INT_W = 3;
  localparam int INT_CARRIER_ON = 0;
  localparam int INT_LINK_CHANGE = 1;
  localparam int INT_SSD = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : pma_pkg

//--- logic/sym_timer_if.sv
// Carrier between the symbol timer and the port logic
`timescale 1ns/1ps
interface sym_timer_if #(parameter int STEP_W = 8);
  logic done;
  logic txClk;
  logic [STEP_W-1:0] step;
  modport timer (output done, output txClk, output step);
  modport user (input done, input txClk, input step);
endinterface : sym_timer_if

//--- logic/sym_timer.sv
// Free-running symbol timer with transmit clock and step count
`timescale 1ns/1ps
module sym_timer #(
  parameter int CYCLES = pma_pkg::SYMBOL_CYCLES,
  parameter int STEP_W = pma_pkg::STEP_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  sym_timer_if.timer tmr
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] HIGH = CNT_W'((CYCLES + 1) / 2);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic clkOut;
    logic [STEP_W-1:0] step;
  } tstate_t;

  tstate_t st_reg;
  tstate_t st_next;
  logic expire;

  assign expire = (st_reg.cnt == LAST);

  always_comb
  begin
    st_next = st_reg;
    // Restart at once; restarting clears the done condition
    st_next.cnt = expire ? '0 : st_reg.cnt + 1'b1;
    // Clock edge rises on each restart
    st_next.clkOut = (st_next.cnt < HIGH);
    if (expire)
    begin
      st_next.step = st_reg.step + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else if (clkEnable)
    begin
      st_reg <= st_next;
    end
  end

  // Gated so a frozen timer does not repeat its expiry
  assign tmr.done = expire & clkEnable;
  assign tmr.txClk = st_reg.clkOut;
  assign tmr.step = st_reg.step;

endmodule : sym_timer

//--- logic/pma_service_port.sv
// Ternary attachment-layer service port with AXI4-Lite control
// ----------------------------------------
// Function
// - Symbol timer runs freely, 40 ns period.
// - Transmit clock follows timer expiries.
// - One coding step per timer expiry.
// - Transmit request issued on each expiry.
// - Type indication always shows T4.
// - IDLE vector sends link integrity pulses.
// - Requested symbols are placed on pairs.
// - Receive vector is IDLE between packets.
// - PREAMBLE from carrier until delimiter recognised.
// - Receive data: three ternary symbols.
// - Receive indications follow recovered symbol timing.
// - Receive data passed only while link OK.
// - Carrier OFF between packets, ON during.
// - Link FAIL, READY or OK reported.
// ----------------------------------------
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module pma_service_port #(
  parameter int SILENCE_SYMBOLS = pma_pkg::IDLE_SILENCE_SYMBOLS,
  parameter int ADDR_W = pma_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txClk,
  output logic txRequest,
  input wire logic txIdle,
  input wire logic [5:0] txSym,
  output logic [5:0] lineTx,
  input wire logic rxStrobeIn,
  input wire logic [5:0] rxSymIn,
  input wire logic carrierIn,
  input wire logic ssdSeen,
  input wire logic linkValid,
  output logic rxIndicate,
  output logic rxIdle,
  output logic rxPreamble,
  output logic [5:0] rxSym,
  output logic carrierStatus,
  output logic [1:0] linkStatus,
  output logic [1:0] pmaType,
  output logic irq
);
  localparam int SIL_W = $clog2(SILENCE_SYMBOLS + 1);
  localparam logic [SIL_W-1:0] SIL_LAST = SIL_W'(SILENCE_SYMBOLS - 1);
  localparam int VW = pma_pkg::PAIRS * pma_pkg::TERN_W;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic awHave;
    logic [ADDR_W-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    pma_pkg::link_control_t linkCtl;
    logic [pma_pkg::INT_W-1:0] intStatus;
    logic [pma_pkg::INT_W-1:0] intMask;
    pma_pkg::link_status_t linkStat;
    logic carrier;
    pma_pkg::rx_state_t rxState;
    logic rxInd;
    logic [VW-1:0] rxVec;
    logic [VW-1:0] lineVec;
    logic collided;
    pma_pkg::idle_phase_t idlePhase;
    logic [SIL_W-1:0] silenceCnt;
  } state_t;

  state_t st_reg;
  state_t st_next;

  sym_timer_if #(.STEP_W(pma_pkg::STEP_W)) tmrBus ();

  sym_timer #(
    .CYCLES(pma_pkg::SYMBOL_CYCLES),
    .STEP_W(pma_pkg::STEP_W)
  ) timer0 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .tmr(tmrBus.timer)
  );

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic pma_pkg::reg_sel_t regSel(input logic [ADDR_W-1:0] a);
    case (a)
      pma_pkg::REG_CTRL: regSel = pma_pkg::SEL_CTRL;
      pma_pkg::REG_STATUS: regSel = pma_pkg::SEL_STATUS;
      pma_pkg::REG_INT_STATUS: regSel = pma_pkg::SEL_INT_STATUS;
      pma_pkg::REG_INT_MASK: regSel = pma_pkg::SEL_INT_MASK;
      pma_pkg::REG_TYPE: regSel = pma_pkg::SEL_TYPE;
      default: regSel = pma_pkg::SEL_NONE;
    endcase
  endfunction : regSel

  function automatic pma_pkg::link_status_t linkEval(input pma_pkg::link_control_t ctl, input logic valid);
    case (ctl)
      pma_pkg::CTL_ENABLE: linkEval = valid ? pma_pkg::LINK_OK : pma_pkg::LINK_FAIL;
      pma_pkg::CTL_SCAN: linkEval = valid ? pma_pkg::LINK_READY : pma_pkg::LINK_FAIL;
      default: linkEval = pma_pkg::LINK_FAIL;
    endcase
  endfunction : linkEval

  // ----------------------------------------
  // Per-pair data drive
  // ----------------------------------------
  // BI pairs go silent once carrier is seen during data, until IDLE
  logic collideNow;
  logic [VW-1:0] dataDrive;
  assign collideNow = st_reg.collided | st_reg.carrier;

  genvar p;
  generate
    for (p = 0; p < pma_pkg::PAIRS; p++)
    begin : g_pair
      if (p == 0)
      begin : g_dedicated
        assign dataDrive[p*2 +: 2] = txSym[p*2 +: 2];
      end
      else
      begin : g_bidir
        assign dataDrive[p*2 +: 2] = collideNow ? pma_pkg::TERN_ZERO : txSym[p*2 +: 2];
      end
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic awTake;
  logic wTake;
  logic arTake;
  logic doWrite;
  logic [pma_pkg::INT_W-1:0] events;
  pma_pkg::link_status_t linkNew;
  pma_pkg::reg_sel_t wSel;
  pma_pkg::reg_sel_t rSel;

  assign awTake = s_axi_awvalid & s_axi_awready;
  assign wTake = s_axi_wvalid & s_axi_wready;
  assign arTake = s_axi_arvalid & s_axi_arready;
  assign doWrite = st_reg.awHave & st_reg.wHave & ~st_reg.bValid;
  assign wSel = regSel(st_reg.awAddr);
  assign rSel = regSel(s_axi_araddr);

  always_comb
  begin
    st_next = st_reg;
    events = '0;
    linkNew = linkEval(st_reg.linkCtl, linkValid);

    // Link and carrier status
    st_next.linkStat = linkNew;
    events[pma_pkg::INT_LINK_CHANGE] = (linkNew != st_reg.linkStat);
    st_next.carrier = carrierIn;
    events[pma_pkg::INT_CARRIER_ON] = carrierIn & ~st_reg.carrier;

    // Receive path on recovered timing
    st_next.rxInd = 1'b0;
    if (rxStrobeIn)
    begin
      st_next.rxInd = (st_reg.linkStat == pma_pkg::LINK_OK);
      if (st_reg.linkStat != pma_pkg::LINK_OK || !carrierIn)
      begin
        st_next.rxState = pma_pkg::RX_IDLE;
      end
      else
      begin
        case (st_reg.rxState)
          pma_pkg::RX_IDLE: st_next.rxState = pma_pkg::RX_PREAMBLE;
          pma_pkg::RX_PREAMBLE:
          begin
            if (ssdSeen)
            begin
              st_next.rxState = pma_pkg::RX_DATA;
              events[pma_pkg::INT_SSD] = 1'b1;
            end
          end
          pma_pkg::RX_DATA: st_next.rxState = pma_pkg::RX_DATA;
          default: st_next.rxState = pma_pkg::RX_IDLE;
        endcase
      end
      // Symbols only carried in data form
      st_next.rxVec = (st_next.rxState == pma_pkg::RX_DATA) ? rxSymIn : '0;
    end

    // Transmit path, one step per expiry
    if (tmrBus.done)
    begin
      if (txIdle || st_reg.linkStat != pma_pkg::LINK_OK)
      begin
        st_next.collided = 1'b0;
        st_next.lineVec = '0;
        case (st_reg.idlePhase)
          pma_pkg::TI_SILENT:
          begin
            if (st_reg.silenceCnt == SIL_LAST)
            begin
              st_next.silenceCnt = '0;
              st_next.idlePhase = pma_pkg::TI_NEG;
            end
            else
            begin
              st_next.silenceCnt = st_reg.silenceCnt + 1'b1;
            end
          end
          pma_pkg::TI_NEG:
          begin
            st_next.lineVec[1:0] = pma_pkg::TERN_NEG;
            st_next.idlePhase = pma_pkg::TI_POS;
          end
          pma_pkg::TI_POS:
          begin
            st_next.lineVec[1:0] = pma_pkg::TERN_POS;
            st_next.idlePhase = pma_pkg::TI_SILENT;
          end
          default: st_next.idlePhase = pma_pkg::TI_SILENT;
        endcase
      end
      else
      begin
        // Idle restarts with silence after a packet
        st_next.idlePhase = pma_pkg::TI_SILENT;
        st_next.silenceCnt = '0;
        st_next.collided = collideNow;
        st_next.lineVec = dataDrive;
      end
    end

    // Write channel
    if (awTake)
    begin
      st_next.awHave = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (wTake)
    begin
      st_next.wHave = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    if (st_reg.bValid && s_axi_bready)
    begin
      st_next.bValid = 1'b0;
    end
    if (doWrite)
    begin
      st_next.awHave = 1'b0;
      st_next.wHave = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = (wSel == pma_pkg::SEL_NONE) ? pma_pkg::RESP_SLVERR : pma_pkg::RESP_OKAY;
      if (st_reg.wStrb[0])
      begin
        case (wSel)
          pma_pkg::SEL_CTRL:
          begin
            // Unused encoding ignored, mode kept
            if (st_reg.wData[pma_pkg::CTRL_LINK_LSB +: 2] != 2'h3)
            begin
              st_next.linkCtl = pma_pkg::link_control_t'(st_reg.wData[pma_pkg::CTRL_LINK_LSB +: 2]);
            end
          end
          pma_pkg::SEL_INT_STATUS:
            st_next.intStatus = st_reg.intStatus & ~st_reg.wData[pma_pkg::INT_W-1:0];
          pma_pkg::SEL_INT_MASK: st_next.intMask = st_reg.wData[pma_pkg::INT_W-1:0];
          default: st_next.linkCtl = st_reg.linkCtl;
        endcase
      end
    end
    // Set wins over a clear in the same cycle
    st_next.intStatus = st_next.intStatus | events;

    // Read channel
    if (st_reg.rValid && s_axi_rready)
    begin
      st_next.rValid = 1'b0;
    end
    if (arTake)
    begin
      st_next.rValid = 1'b1;
      st_next.rResp = pma_pkg::RESP_OKAY;
      st_next.rData = pma_pkg::DATA_ZERO;
      case (rSel)
        pma_pkg::SEL_CTRL: st_next.rData[pma_pkg::CTRL_LINK_LSB +: 2] = st_reg.linkCtl;
        pma_pkg::SEL_STATUS:
        begin
          st_next.rData[pma_pkg::STAT_LINK_LSB +: 2] = st_reg.linkStat;
          st_next.rData[pma_pkg::STAT_CARRIER] = st_reg.carrier;
          st_next.rData[pma_pkg::STAT_RX_LSB +: 2] = st_reg.rxState;
          st_next.rData[pma_pkg::STAT_STEP_LSB +: pma_pkg::STEP_W] = tmrBus.step;
        end
        pma_pkg::SEL_INT_STATUS: st_next.rData[pma_pkg::INT_W-1:0] = st_reg.intStatus;
        pma_pkg::SEL_INT_MASK: st_next.rData[pma_pkg::INT_W-1:0] = st_reg.intMask;
        pma_pkg::SEL_TYPE: st_next.rData[1:0] = pma_pkg::PMA_TYPE_T4;
        default: st_next.rResp = pma_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else if (clkEnable)
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = ~st_reg.awHave & ~st_reg.bValid;
  assign s_axi_wready = ~st_reg.wHave & ~st_reg.bValid;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_arready = ~st_reg.rValid;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;

  assign txClk = tmrBus.txClk;
  assign txRequest = tmrBus.done;
  assign lineTx = st_reg.lineVec;
  assign rxIndicate = st_reg.rxInd;
  assign rxIdle = (st_reg.rxState == pma_pkg::RX_IDLE);
  assign rxPreamble = (st_reg.rxState == pma_pkg::RX_PREAMBLE);
  assign rxSym = st_reg.rxVec;
  assign carrierStatus = st_reg.carrier;
  assign linkStatus = st_reg.linkStat;
  assign pmaType = pma_pkg::PMA_TYPE_T4;
  assign irq = |(st_reg.intStatus & st_reg.intMask);

endmodule : pma_service_port

//--- bench/pma_service_port_assertions.sv
// Assertion checker for the ternary service port
`timescale 1ns/1ps
module pma_service_port_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic txRequest,
  input wire logic txClk,
  input wire logic txIdle,
  input wire logic [5:0] txSym,
  input wire logic [5:0] lineTx,
  input wire logic rxStrobeIn,
  input wire logic [5:0] rxSymIn,
  input wire logic carrierIn,
  input wire logic ssdSeen,
  input wire logic rxIndicate,
  input wire logic rxIdle,
  input wire logic rxPreamble,
  input wire logic [5:0] rxSym,
  input wire logic carrierStatus,
  input wire logic [1:0] linkStatus,
  input wire logic [1:0] pmaType
);
  // ----
  // Properties
  // ----
  default clocking dc @(posedge core_clk);
  endclocking
  // A frozen port stretches every spacing, so checks pause with the enable
  default disable iff (!reset_n || !clkEnable);
  // Collision latch as seen from the request stream, cleared by an idle request
  logic collideSeen;
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      collideSeen <= 1'b0;
    end
    else if (txRequest)
    begin
      collideSeen <= !txIdle && linkStatus == 2'h2 && (collideSeen || carrierStatus);
    end
  end
  a_type_constant:
    assert property (pmaType == 2'h1) else $error("type indication wrong");
  a_request_spacing:
    assert property (txRequest |=> !txRequest [*4] ##1 txRequest) else $error("request spacing wrong");
  a_clock_lockstep:
    assert property (txRequest |=> $rose(txClk) ##0 txClk [*3] ##1 !txClk) else $error("transmit clock out of step");
  // Collision blanks two pairs until idle, so the full vector needs a quiet line
  a_line_data:
    assert property (txRequest && !txIdle && linkStatus == 2'h2 && !carrierStatus && !collideSeen
      |=> lineTx == $past(txSym)) else $error("line symbols wrong");
  a_collide_silence:
    assert property (txRequest && !txIdle && linkStatus == 2'h2 && (carrierStatus || collideSeen)
      |=> lineTx[5:2] == 4'h0 && lineTx[1:0] == $past(txSym[1:0])) else $error("collision pairs not silent");
  a_line_hold:
    assert property (!txRequest |=> $stable(lineTx)) else $error("line changed between requests");
  a_rx_forward:
    assert property (rxStrobeIn && linkStatus == 2'h2 |=> rxIndicate) else $error("indication missing");
  a_rx_gated:
    assert property (rxIndicate |-> $past(rxStrobeIn) && $past(linkStatus) == 2'h2) else $error("stray indication");
  a_rx_forms:
    assert property ((rxIdle || rxPreamble) |-> rxSym == 6'h00 && !(rxIdle && rxPreamble)) else $error("bad rx form");
  a_preamble_entry:
    assert property (rxStrobeIn && rxIdle && carrierIn && carrierStatus && !ssdSeen && linkStatus == 2'h2
      |=> rxPreamble && !rxIdle) else $error("preamble missing");
  a_data_entry:
    assert property (rxStrobeIn && rxPreamble && carrierIn && carrierStatus && ssdSeen && linkStatus == 2'h2
      |=> !rxIdle && !rxPreamble && rxSym == $past(rxSymIn)) else $error("data not delivered");
  a_idle_between:
    assert property (rxStrobeIn && !carrierIn && !carrierStatus |=> rxIdle) else $error("idle missing");
  a_carrier_follow:
    assert property (1'b1 |=> carrierStatus == $past(carrierIn)) else $error("carrier status lags");
endmodule : pma_service_port_assertions

//--- bench/pma_client_model.sv
// Client model: one transmit vector per request
`timescale 1ns/1ps
module pma_client_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic txRequest,
  input wire logic nextIdle,
  input wire logic [5:0] nextSym,
  output logic txIdle,
  output logic [5:0] txSym
);
  // ----
  // Vector update
  // ----
  // Symbols toggle while idle so a design reading them then shows it
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      txIdle <= 1'b1;
      txSym <= 6'h15;
    end
    else if (txRequest)
    begin
      txIdle <= nextIdle;
      txSym <= nextIdle ? ~txSym : nextSym;
    end
  end
endmodule : pma_client_model

//--- bench/ternary_pma_service_port_test.sv
// Self-checking bench for the ternary service port
`timescale 1ns/1ps
module ternary_pma_service_port_test;
  // ----
  // Signals
  // ----
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEnable = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txClk, txRequest, txIdle, irq;
  logic rxIndicate, rxIdle, rxPreamble, carrierStatus;
  logic [1:0] s_axi_bresp, s_axi_rresp, linkStatus, pmaType;
  logic [31:0] s_axi_rdata;
  logic [5:0] txSym, lineTx, rxSym;
  logic [5:0] nextSym = 6'h00, rxSymIn = 6'h00;
  logic nextIdle = 1'b1, rxStrobeIn = 1'b0, carrierIn = 1'b0, ssdSeen = 1'b0, linkValid = 1'b0;
  logic [1:0] linkCtl [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic linkIn [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [1:0] linkExp [5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h2};
  logic [5:0] txVec [4] = '{6'h1D, 6'h37, 6'h13, 6'h00};
  logic [5:0] idleExp [6] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h03, 6'h01};
  logic [6:0] frozenOut;
  int mismatches = 0;
  int totalChecks = 0;
  always #4 core_clk = ~core_clk;
  pma_service_port #(.SILENCE_SYMBOLS(4)) u_pma_service_port (.core_clk, .reset_n, .clkEnable, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txClk, .txRequest, .txIdle, .txSym, .lineTx, .rxStrobeIn, .rxSymIn, .carrierIn,
    .ssdSeen, .linkValid, .rxIndicate, .rxIdle, .rxPreamble, .rxSym, .carrierStatus, .linkStatus, .pmaType, .irq);
  pma_client_model u_pma_client_model (.core_clk, .reset_n, .txRequest, .nextIdle, .nextSym, .txIdle, .txSym);
  // ----
  // Tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_up();
    mismatches++;
    report_and_stop();
  endtask : give_up
  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] expResp);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(expResp));
        break;
      end
    end
    if (n == 40) give_up();
  endtask : reg_write
  task automatic reg_read(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp,
    input logic [1:0] expResp);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        check(s_axi_rdata & mask, exp);
        check(32'(s_axi_rresp), 32'(expResp));
        break;
      end
    end
    if (n == 40) give_up();
  endtask : reg_read
  task automatic wait_req();
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (txRequest) break;
    end
    if (n == 20) give_up();
  endtask : wait_req
  // Two requests per vector: one to load the client, one for the port
  task automatic send(input logic [5:0] sym, input logic [5:0] exp);
    @(posedge core_clk);
    nextIdle <= 1'b0;
    nextSym <= sym;
    wait_req();
    wait_req();
    #1;
    check(32'(lineTx), 32'(exp));
  endtask : send
  task automatic rx_strobe(input logic ssd, input logic [5:0] sym, input logic [8:0] exp);
    @(posedge core_clk);
    rxStrobeIn <= 1'b1;
    ssdSeen <= ssd;
    rxSymIn <= sym;
    @(posedge core_clk);
    rxStrobeIn <= 1'b0;
    #1;
    check(32'({rxIndicate, rxIdle, rxPreamble, rxSym}), 32'(exp));
  endtask : rx_strobe
  task automatic set_carrier(input logic on);
    @(posedge core_clk);
    carrierIn <= on;
    repeat (2) @(posedge core_clk);
  endtask : set_carrier
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    check(32'(pmaType), 32'h1);
    reg_read(8'h10, 32'hFFFFFFFF, 32'h1, 2'h0);
    reg_read(8'h04, 32'h3, 32'h0, 2'h0);
    check(32'({rxIdle, rxPreamble, lineTx}), 32'h80);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      reg_write(8'h00, 32'(linkCtl[i]), 2'h0);
      linkValid <= linkIn[i];
      repeat (3) @(posedge core_clk);
      check(32'(linkStatus), 32'(linkExp[i]));
      reg_read(8'h04, 32'h3, 32'(linkExp[i]), 2'h0);
    end
    $display("link test done");
    for (int i = 0; i < 4; i++)
      send(txVec[i], txVec[i]);
    @(posedge core_clk);
    nextIdle <= 1'b1;
    wait_req();
    for (int i = 0; i < 6; i++)
    begin
      wait_req();
      #1;
      check(32'(lineTx), 32'(idleExp[i]));
    end
    $display("transmit test done");
    set_carrier(1'b1);
    rx_strobe(1'b0, 6'h15, 9'h140);
    rx_strobe(1'b1, 6'h1D, 9'h11D);
    rx_strobe(1'b0, 6'h37, 9'h137);
    set_carrier(1'b0);
    rx_strobe(1'b0, 6'h1D, 9'h180);
    reg_write(8'h00, 32'h2, 2'h0);
    set_carrier(1'b1);
    rx_strobe(1'b1, 6'h1D, 9'h080);
    set_carrier(1'b0);
    reg_write(8'h00, 32'h0, 2'h0);
    set_carrier(1'b1);
    send(6'h1D, 6'h01);
    set_carrier(1'b0);
    send(6'h37, 6'h03);
    @(posedge core_clk);
    nextIdle <= 1'b1;
    repeat (2) wait_req();
    send(6'h37, 6'h37);
    @(posedge core_clk);
    nextIdle <= 1'b1;
    repeat (2) wait_req();
    $display("receive test done");
    reg_read(8'h08, 32'hFFFFFFFF, 32'h7, 2'h0);
    check(32'(irq), 32'h0);
    reg_write(8'h0C, 32'h1, 2'h0);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h1);
    reg_write(8'h08, 32'h1, 2'h0);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h0);
    reg_read(8'h08, 32'hFFFFFFFF, 32'h6, 2'h0);
    reg_write(8'h20, 32'h1, 2'h2);
    reg_read(8'h20, 32'hFFFFFFFF, 32'h0, 2'h2);
    $display("interrupt test done");
    @(posedge core_clk);
    clkEnable <= 1'b0;
    @(posedge core_clk);
    frozenOut = {txClk, lineTx};
    repeat (12)
    begin
      @(posedge core_clk);
      check(32'({txRequest, txClk, lineTx}), 32'({1'b0, frozenOut}));
    end
    clkEnable <= 1'b1;
    wait_req();
    $display("freeze test done");
    report_and_stop();
  end
endmodule : ternary_pma_service_port_test

bind pma_service_port pma_service_port_assertions u_pma_service_port_assertions (.core_clk, .reset_n, .clkEnable,
  .txRequest, .txClk, .txIdle, .txSym, .lineTx, .rxStrobeIn, .rxSymIn, .carrierIn, .ssdSeen, .rxIndicate, .rxIdle,
  .rxPreamble, .rxSym, .carrierStatus, .linkStatus, .pmaType);
